// [core/thc_edge_det.sv]
module thc_edge_det (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin,
   input wire logic fall_sel,
   input wire logic both_sel,
   output logic hit
);
   logic prev_ff;
   logic nxt_prev;
   logic nxt_hit;
   logic hit_ff;
   logic armed_ff;
   logic nxt_armed;

   always_comb begin
      nxt_prev = pin;
      nxt_armed = 1'b1;
      if (both_sel) begin
         nxt_hit = pin ^ prev_ff;
      end else if (fall_sel) begin
         nxt_hit = prev_ff & ~pin;
      end else begin
         nxt_hit = ~prev_ff & pin;
      end
      // The history bit is not yet a real pin level right after reset, so a pin that
      // idles high would otherwise fake an edge there.
      nxt_hit = nxt_hit & armed_ff;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= 1'b0;
         hit_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         hit_ff <= nxt_hit;
         armed_ff <= nxt_armed;
      end
   end

   assign hit = hit_ff;
endmodule : thc_edge_det

// [core/thc_hit_select.sv]
// Contract
// RL1: Extended mode result is second operand minus first, first operand fixed to start.
// RL2: Extended mode takes up to three stop hits and second operand picks hit one, two or three.
// RL3: Extended mode offers no stop-to-stop interval; all results reference the start.
// RL4: Direct mode result is first operand minus second operand.
// RL5: Direct mode operands may be start or any numbered hit on either stop channel.
// RL6: Analog disabled makes stop channels digital inputs; enabled routes the analog path.
// RL7: Capacitor charge time selects 90, 120, 150 or 300 us, defaulting to 300 us.
// RL8: Auto summing computes all three hit results and their total into result 4.
// RL9: Extended mode times out when hits are not reached within 64 to 1024 us.
// RL10: Each stop channel has its own expected hit count deciding when collection ends.
// RL11: Start triggers on falling edge when selected, rising edge otherwise.
// RL12: Each stop channel triggers on rising, falling or both edges by its own selects.
// RL13: Interrupts fire when the expected hits arrive and when the counter overflows; irq_overflow fires only for a wrap during hit collection.
// RL14: Subtraction starts only after needed hits or timeout, and timeout marks invalid.
module thc_hit_select #(
   parameter int TS_W = thc_pkg::TS_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start_pin,
   input wire logic stop_a_dig,
   input wire logic stop_b_dig,
   input wire logic stop_a_ana,
   input wire logic stop_b_ana,
   input wire logic analog_enable,
   input wire logic [1:0] cap_charge_time,
   input wire logic mode_extended,
   input wire logic [2:0] first_operand_select,
   input wire logic [2:0] second_operand_select,
   input wire logic auto_sum_enable,
   input wire logic [3:0] hit_timeout_select,
   input wire logic [1:0] expected_hits_a,
   input wire logic [1:0] expected_hits_b,
   input wire logic start_fall,
   input wire logic stop_a_fall,
   input wire logic stop_a_both,
   input wire logic stop_b_fall,
   input wire logic stop_b_both,
   output logic load_capacitor,
   output logic [TS_W-1:0] result,
   output logic [TS_W-1:0] result_sum,
   output logic result_valid,
   output logic result_invalid,
   output logic irq_hits,
   output logic irq_overflow,
   output logic busy
);
   if (TS_W < 8 || TS_W > 32) begin : g_chk
      $error("TS_W must be 8..32");
   end

   // -----------------------------------------------------------------------
   // Input path and edge detection
   // -----------------------------------------------------------------------
   logic stop_a_src;
   logic stop_b_src;
   logic start_hit;
   logic a_hit;
   logic b_hit;

   assign stop_a_src = analog_enable ? stop_a_ana : stop_a_dig;  // [RL6]
   assign stop_b_src = analog_enable ? stop_b_ana : stop_b_dig;  // [RL6]

   thc_edge_det u_start (
      .mclk(mclk), .rst_n(rst_n), .pin(start_pin),
      .fall_sel(start_fall), .both_sel(1'b0), .hit(start_hit)  // [RL11]
   );
   thc_edge_det u_stop_a (
      .mclk(mclk), .rst_n(rst_n), .pin(stop_a_src),
      .fall_sel(stop_a_fall), .both_sel(stop_a_both), .hit(a_hit)  // [RL12]
   );
   thc_edge_det u_stop_b (
      .mclk(mclk), .rst_n(rst_n), .pin(stop_b_src),
      .fall_sel(stop_b_fall), .both_sel(stop_b_both), .hit(b_hit)  // [RL12]
   );

   // -----------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------
   // Captured timestamp of a source code; unused codes give the start time.
   function automatic logic [TS_W-1:0] pick(input logic [2:0] src,
                                           input logic [TS_W-1:0] st,
                                           input logic [3*TS_W-1:0] ta,
                                           input logic [3*TS_W-1:0] tb);
      logic [TS_W-1:0] v;
      v = st;
      case (src)
         3'h1: v = ta[TS_W-1:0];
         3'h2: v = ta[2*TS_W-1:TS_W];
         3'h3: v = ta[3*TS_W-1:2*TS_W];
         3'h5: v = tb[TS_W-1:0];
         3'h6: v = tb[2*TS_W-1:TS_W];
         3'h7: v = tb[3*TS_W-1:2*TS_W];
         default: v = st;
      endcase
      return v;
   endfunction : pick

   // True once the hit named by a source code has been captured.
   function automatic logic have(input logic [2:0] src, input logic [1:0] na,
                                 input logic [1:0] nb);
      logic r;
      r = 1'b1;
      if (src >= thc_pkg::SRC_B1) begin
         r = nb >= 2'(src - thc_pkg::SRC_B1 + 3'h1);
      end else if (src >= thc_pkg::SRC_A1) begin
         r = na >= src[1:0];
      end
      return r;
   endfunction : have

   // -----------------------------------------------------------------------
   // Charge time of the load capacitor
   // -----------------------------------------------------------------------
   logic [15:0] chg_cnt_ff;
   logic [15:0] nxt_chg_cnt;
   logic load_cap_ff;
   logic nxt_load_cap;
   logic [15:0] chg_len;

   always_comb begin
      case (cap_charge_time)  // [RL7]
         2'h0: chg_len = 16'(thc_pkg::CHG_90_CYC);
         2'h1: chg_len = 16'(thc_pkg::CHG_120_CYC);
         2'h2: chg_len = 16'(thc_pkg::CHG_150_CYC);
         default: chg_len = 16'(thc_pkg::CHG_300_CYC);
      endcase
      nxt_chg_cnt = chg_cnt_ff;
      nxt_load_cap = load_cap_ff;
      if (!analog_enable) begin
         nxt_chg_cnt = 16'h0;
         nxt_load_cap = 1'b0;
      end else if (load_cap_ff) begin
         if (chg_cnt_ff >= chg_len - 16'h1) begin
            nxt_load_cap = 1'b0;
         end else begin
            nxt_chg_cnt = chg_cnt_ff + 16'h1;
         end
      end else if (start_hit) begin
         // A new measurement recharges the capacitor before the next shot.
         nxt_load_cap = 1'b1;
         nxt_chg_cnt = 16'h0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chg_cnt_ff <= 16'h0;
         load_cap_ff <= 1'b0;
      end else begin
         chg_cnt_ff <= nxt_chg_cnt;
         load_cap_ff <= nxt_load_cap;
      end
   end

   // -----------------------------------------------------------------------
   // Measurement sequencer
   // -----------------------------------------------------------------------
   thc_pkg::thc_state_t st_ff;
   thc_pkg::thc_state_t nxt_st;
   logic [TS_W-1:0] ctr_ff, nxt_ctr;
   logic [TS_W-1:0] t_start_ff, nxt_t_start;
   logic [3*TS_W-1:0] ta_ff, nxt_ta;
   logic [3*TS_W-1:0] tb_ff, nxt_tb;
   logic [1:0] na_ff, nxt_na;
   logic [1:0] nb_ff, nxt_nb;
   logic [19:0] tmo_ff, nxt_tmo;
   logic tmo_hit_ff, nxt_tmo_hit;
   logic [TS_W-1:0] res_ff, nxt_res;
   logic [TS_W-1:0] sum_ff, nxt_sum;
   logic val_ff, nxt_val;
   logic inv_ff, nxt_inv;
   logic irq_h_ff, nxt_irq_h;
   logic irq_o_ff, nxt_irq_o;
   logic [2:0] op1;
   logic [2:0] op2;
   logic [19:0] tmo_len;
   logic hits_done;
   logic ops_ready;
   logic [TS_W-1:0] d1, d2, d3;

   always_comb begin
      // Extended mode pins operand one to start and uses channel A hits.
      op1 = mode_extended ? thc_pkg::SRC_START : first_operand_select;  // [RL1] [RL3] [RL5]
      op2 = second_operand_select;                                      // [RL5]
      if (mode_extended && (second_operand_select[2] || second_operand_select == 3'h0)) begin
         op2 = thc_pkg::SRC_A1;  // [RL2] [RL3]
      end
      tmo_len = 20'(thc_pkg::TIMO_MIN_CYC) * (20'(hit_timeout_select) + 20'h1);  // [RL9]
      hits_done = (na_ff >= expected_hits_a) && (nb_ff >= expected_hits_b);  // [RL10]
      ops_ready = have(op1, na_ff, nb_ff) && have(op2, na_ff, nb_ff);
      d1 = ta_ff[TS_W-1:0] - t_start_ff;
      d2 = ta_ff[2*TS_W-1:TS_W] - t_start_ff;
      d3 = ta_ff[3*TS_W-1:2*TS_W] - t_start_ff;

      nxt_st = st_ff;
      nxt_ctr = ctr_ff + {{(TS_W-1){1'b0}}, 1'b1};
      nxt_t_start = t_start_ff;
      nxt_ta = ta_ff;
      nxt_tb = tb_ff;
      nxt_na = na_ff;
      nxt_nb = nb_ff;
      nxt_tmo = tmo_ff;
      nxt_tmo_hit = tmo_hit_ff;
      nxt_res = res_ff;
      nxt_sum = sum_ff;
      nxt_val = 1'b0;
      nxt_inv = inv_ff;
      nxt_irq_h = 1'b0;
      nxt_irq_o = 1'b0;
      case (st_ff)
         thc_pkg::THC_IDLE: begin
            if (start_hit) begin
               nxt_st = thc_pkg::THC_COLLECT;
               nxt_t_start = ctr_ff;
               nxt_na = 2'h0;
               nxt_nb = 2'h0;
               nxt_tmo = 20'h0;
               nxt_tmo_hit = 1'b0;
            end
         end
         thc_pkg::THC_COLLECT: begin
            nxt_tmo = tmo_ff + 20'h1;
            if (a_hit && na_ff < 2'(thc_pkg::MAX_HITS) && na_ff < expected_hits_a) begin
               nxt_ta[na_ff*TS_W +: TS_W] = ctr_ff;  // [RL2]
               nxt_na = na_ff + 2'h1;
            end
            if (b_hit && nb_ff < 2'(thc_pkg::MAX_HITS) && nb_ff < expected_hits_b) begin
               nxt_tb[nb_ff*TS_W +: TS_W] = ctr_ff;
               nxt_nb = nb_ff + 2'h1;
            end
            if (hits_done && ops_ready) begin
               nxt_irq_h = 1'b1;  // [RL13]
               nxt_st = thc_pkg::THC_CALC;  // [RL14]
            end else if (ctr_ff == {TS_W{1'b1}}) begin
               // The counter wrap is treated like a timeout in every mode.
               nxt_irq_o = 1'b1;  // [RL13]
               nxt_tmo_hit = 1'b1;
               nxt_st = thc_pkg::THC_CALC;
            end else if (mode_extended && tmo_ff >= tmo_len - 20'h1) begin
               nxt_tmo_hit = 1'b1;  // [RL9]
               nxt_st = thc_pkg::THC_CALC;  // [RL14]
            end
         end
         thc_pkg::THC_CALC: begin
            if (mode_extended) begin
               nxt_res = pick(op2, t_start_ff, ta_ff, tb_ff) - t_start_ff;  // [RL1]
            end else begin
               nxt_res = pick(op1, t_start_ff, ta_ff, tb_ff)
                         - pick(op2, t_start_ff, ta_ff, tb_ff);  // [RL4]
            end
            nxt_sum = (mode_extended && auto_sum_enable) ? d1 + d2 + d3 : sum_ff;  // [RL8]
            nxt_inv = tmo_hit_ff;  // [RL14]
            nxt_val = 1'b1;
            nxt_st = thc_pkg::THC_DONE;
         end
         thc_pkg::THC_DONE: begin
            nxt_st = thc_pkg::THC_IDLE;
         end
         default: nxt_st = thc_pkg::THC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= thc_pkg::THC_IDLE;
         ctr_ff <= '0;
         t_start_ff <= '0;
         ta_ff <= '0;
         tb_ff <= '0;
         na_ff <= 2'h0;
         nb_ff <= 2'h0;
         tmo_ff <= 20'h0;
         tmo_hit_ff <= 1'b0;
         res_ff <= '0;
         sum_ff <= '0;
         val_ff <= 1'b0;
         inv_ff <= 1'b0;
         irq_h_ff <= 1'b0;
         irq_o_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ctr_ff <= nxt_ctr;
         t_start_ff <= nxt_t_start;
         ta_ff <= nxt_ta;
         tb_ff <= nxt_tb;
         na_ff <= nxt_na;
         nb_ff <= nxt_nb;
         tmo_ff <= nxt_tmo;
         tmo_hit_ff <= nxt_tmo_hit;
         res_ff <= nxt_res;
         sum_ff <= nxt_sum;
         val_ff <= nxt_val;
         inv_ff <= nxt_inv;
         irq_h_ff <= nxt_irq_h;
         irq_o_ff <= nxt_irq_o;
      end
   end

   // -----------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------
   logic busy_ff;
   logic nxt_busy;

   assign nxt_busy = (nxt_st != thc_pkg::THC_IDLE);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_busy;
      end
   end

   assign load_capacitor = load_cap_ff;
   assign result = res_ff;
   assign result_sum = sum_ff;
   assign result_valid = val_ff;
   assign result_invalid = inv_ff;
   assign irq_hits = irq_h_ff;
   assign irq_overflow = irq_o_ff;
   assign busy = busy_ff;
endmodule : thc_hit_select

// [core/thc_pkg.sv]
package thc_pkg;
   // -----------------------------------------------------------------------
   // Widths and timing
   // -----------------------------------------------------------------------
   localparam int TS_W = 24;
   localparam int CLK_MHZ = 125;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MAX_HITS = 3;
   localparam int TIMO_MIN_US = 64;
   localparam int TIMO_MAX_US = 1024;
   localparam int TIMO_MIN_CYC = TIMO_MIN_US * 1000 / CLK_PERIOD_NS;
   localparam int CHG_90_US = 90;
   localparam int CHG_120_US = 120;
   localparam int CHG_150_US = 150;
   localparam int CHG_300_US = 300;
   localparam int CHG_90_CYC = CHG_90_US * 1000 / CLK_PERIOD_NS;
   localparam int CHG_120_CYC = CHG_120_US * 1000 / CLK_PERIOD_NS;
   localparam int CHG_150_CYC = CHG_150_US * 1000 / CLK_PERIOD_NS;
   localparam int CHG_300_CYC = CHG_300_US * 1000 / CLK_PERIOD_NS;
   localparam logic [1:0] CHG_SEL_RST = 2'h3;

   // -----------------------------------------------------------------------
   // Operand source codes: 0 start, 1..3 channel A hits, 5..7 channel B hits
   // -----------------------------------------------------------------------
   localparam logic [2:0] SRC_START = 3'h0;
   localparam logic [2:0] SRC_A1 = 3'h1;
   localparam logic [2:0] SRC_B1 = 3'h5;

   typedef enum logic [1:0] {
      THC_IDLE = 2'b00,
      THC_COLLECT = 2'b01,
      THC_CALC = 2'b10,
      THC_DONE = 2'b11
   } thc_state_t;
endpackage : thc_pkg

// [verif/thc_hit_select_properties.sv]
module thc_hit_select_properties #(
   parameter int TS_W = thc_pkg::TS_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic analog_enable,
   input wire logic [1:0] cap_charge_time,
   input wire logic load_capacitor,
   input wire logic [TS_W-1:0] result,
   input wire logic result_valid,
   input wire logic result_invalid,
   input wire logic irq_hits,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   int cap_cnt_ff;
   int nxt_cap_cnt;
   function automatic int chg_cyc(input logic [1:0] s);
      case (s)
         2'h0: return thc_pkg::CHG_90_CYC;
         2'h1: return thc_pkg::CHG_120_CYC;
         2'h2: return thc_pkg::CHG_150_CYC;
         default: return thc_pkg::CHG_300_CYC;
      endcase
   endfunction : chg_cyc
   always_comb begin
      nxt_cap_cnt = load_capacitor ? cap_cnt_ff + 1 : 0;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_cnt_ff <= 0;
      end else begin
         cap_cnt_ff <= nxt_cap_cnt;
      end
   end
   sequence s_hits;
      irq_hits;
   endsequence
   sequence s_answer;
      ##[1:2] result_valid;
   endsequence
   hits_answer_a: assert property (s_hits |-> s_answer)
      else $error("no result after hit interrupt");
   valid_pulse_a: assert property (result_valid |=> !result_valid)
      else $error("result valid longer than one cycle");
   irq_pulse_a: assert property (irq_hits |=> !irq_hits)
      else $error("hit interrupt longer than one cycle");
   busy_release_a: assert property (result_valid |-> ##[1:2] !busy)
      else $error("busy stays after result");
   result_hold_a: assert property ($changed(result) |-> result_valid)
      else $error("result changed without valid");
   invalid_hold_a: assert property ($changed(result_invalid) |-> result_valid)
      else $error("invalid flag changed without valid");
   cap_analog_a: assert property ($rose(load_capacitor) |-> analog_enable)
      else $error("capacitor charged with analog unit off");
   cap_len_a: assert property ($fell(load_capacitor) |->
      cap_cnt_ff >= chg_cyc(cap_charge_time) - 2 && cap_cnt_ff <= chg_cyc(cap_charge_time) + 2)
      else $error("capacitor charge time wrong");
endmodule : thc_hit_select_properties

// [verif/thc_hit_select_tb.sv]
module thc_hit_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TS_W = thc_pkg::TS_W;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic analog_enable = 1'b0;
   logic [1:0] cap_charge_time = 2'h0;
   logic mode_extended = 1'b0;
   logic [2:0] op1 = 3'h0;
   logic [2:0] op2 = 3'h0;
   logic auto_sum = 1'b0;
   logic [3:0] timo_sel = 4'h0;
   logic [1:0] exp_a = 2'h0;
   logic [1:0] exp_b = 2'h0;
   logic start_fall = 1'b0;
   logic a_fall = 1'b0;
   logic a_both = 1'b0;
   logic b_fall = 1'b0;
   logic b_both = 1'b0;
   wire logic start_pin, stop_a_dig, stop_b_dig, stop_a_ana, stop_b_ana;
   logic load_capacitor, result_valid, result_invalid, irq_hits, irq_overflow, busy;
   logic [TS_W-1:0] result, result_sum, cap_res, cap_sum;
   logic cap_inv;
   int n_fail = 0;
   int check_count = 0;
   int nv = 0;
   int nv0 = 0;
   int n_ovf = 0;
   int n;
   thc_pulse_src src (.mclk(mclk), .ana_sel(analog_enable), .start_pin(start_pin),
      .stop_a_dig(stop_a_dig), .stop_b_dig(stop_b_dig), .stop_a_ana(stop_a_ana),
      .stop_b_ana(stop_b_ana));
   thc_hit_select #(.TS_W(TS_W)) DUT (.mclk(mclk), .rst_n(rst_n), .start_pin(start_pin),
      .stop_a_dig(stop_a_dig), .stop_b_dig(stop_b_dig), .stop_a_ana(stop_a_ana),
      .stop_b_ana(stop_b_ana), .analog_enable(analog_enable),
      .cap_charge_time(cap_charge_time), .mode_extended(mode_extended),
      .first_operand_select(op1), .second_operand_select(op2), .auto_sum_enable(auto_sum),
      .hit_timeout_select(timo_sel), .expected_hits_a(exp_a), .expected_hits_b(exp_b),
      .start_fall(start_fall), .stop_a_fall(a_fall), .stop_a_both(a_both),
      .stop_b_fall(b_fall), .stop_b_both(b_both), .load_capacitor(load_capacitor),
      .result(result), .result_sum(result_sum), .result_valid(result_valid),
      .result_invalid(result_invalid), .irq_hits(irq_hits), .irq_overflow(irq_overflow),
      .busy(busy));
   initial forever #4 mclk = ~mclk;
   // Results are captured at the falling edge, where the one-cycle valid pulse is settled.
   always @(negedge mclk) begin
      if (result_valid === 1'b1) begin
         cap_res = result;
         cap_sum = result_sum;
         cap_inv = result_invalid;
         nv++;
      end
      if (irq_overflow === 1'b1) begin
         n_ovf++;
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [TS_W-1:0] exp, input logic [TS_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic give_up(input string what);
      n_fail++;
      $display("[FAIL] %s expected done seen stuck", what);
      print_verdict();
   endtask : give_up
   // The result count is marked before the last stimulus, since the result can
   // arrive while the pulse source is still finishing its gap.
   task automatic wait_res(input int bound, output int cnt);
      cnt = 0;
      while (nv == nv0 && cnt < bound) begin
         @(negedge mclk);
         cnt++;
      end
      if (nv == nv0) give_up("result wait");
   endtask : wait_res
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 100) begin
         @(negedge mclk);
         k++;
      end
      if (busy !== 1'b0) give_up("busy wait");
      repeat (4) @(negedge mclk);
   endtask : wait_idle
   task automatic t_ext();
      for (int k = 1; k <= 3; k++) begin
         mode_extended = 1'b1;
         op1 = 3'h5;
         op2 = 3'(k);
         auto_sum = 1'b1;
         exp_a = 2'h3;
         repeat (4) @(negedge mclk);
         src.pg(0, 2, 8);
         nv0 = nv;
         repeat (3) src.pg(1, 2, 8);
         wait_res(50, n);
         chk("ext result", TS_W'(10 * k), cap_res);
         chk("ext sum", 24'h00003c, cap_sum);
         chk("ext invalid", 24'h0, TS_W'(cap_inv));
         wait_idle();
      end
      $display("test extended done");
   endtask : t_ext
   task automatic t_dir();
      logic [2:0] o1[3] = '{3'h2, 3'h5, 3'h1};
      logic [2:0] o2[3] = '{3'h5, 3'h1, 3'h0};
      int ex[3] = '{10, 5, 10};
      for (int i = 0; i < 3; i++) begin
         mode_extended = 1'b0;
         auto_sum = 1'b0;
         op1 = o1[i];
         op2 = o2[i];
         exp_a = 2'h2;
         exp_b = 2'h1;
         repeat (4) @(negedge mclk);
         src.pg(0, 2, 8);
         nv0 = nv;
         src.pg(1, 2, 3);
         src.pg(2, 2, 8);
         src.pg(1, 2, 8);
         wait_res(50, n);
         chk("direct result", TS_W'(ex[i]), cap_res);
         wait_idle();
      end
      $display("test direct done");
   endtask : t_dir
   task automatic t_edge();
      int k;
      analog_enable = 1'b1;
      start_fall = 1'b1;
      a_fall = 1'b1;
      a_both = 1'b1;
      mode_extended = 1'b1;
      op2 = 3'h2;
      exp_a = 2'h2;
      exp_b = 2'h0;
      repeat (4) @(negedge mclk);
      src.pg(0, 4, 6);
      nv0 = nv;
      src.pg(1, 5, 10);
      wait_res(50, n);
      chk("edge result", 24'h00000b, cap_res);
      chk("load cap on", 24'h1, TS_W'(load_capacitor));
      k = 0;
      while (load_capacitor !== 1'b0 && k < 12000) begin
         @(negedge mclk);
         k++;
      end
      if (load_capacitor !== 1'b0) give_up("charge wait");
      wait_idle();
      analog_enable = 1'b0;
      start_fall = 1'b0;
      a_both = 1'b0;
      b_fall = 1'b1;
      mode_extended = 1'b0;
      op1 = 3'h5;
      op2 = 3'h0;
      exp_a = 2'h0;
      exp_b = 2'h1;
      repeat (4) @(negedge mclk);
      src.pg(0, 2, 8);
      nv0 = nv;
      src.pg(2, 3, 5);
      wait_res(50, n);
      chk("fall result", 24'h00000d, cap_res);
      chk("load cap off", 24'h0, TS_W'(load_capacitor));
      wait_idle();
      $display("test edges done");
   endtask : t_edge
   task automatic t_timo();
      mode_extended = 1'b1;
      op2 = 3'h1;
      exp_a = 2'h1;
      exp_b = 2'h0;
      timo_sel = 4'h0;
      repeat (4) @(negedge mclk);
      nv0 = nv;
      src.pg(0, 2, 0);
      wait_res(9000, n);
      chk("timeout invalid", 24'h1, TS_W'(cap_inv));
      chk("timeout window", 24'h1, TS_W'(n >= 7995 && n <= 8010));
      wait_idle();
      $display("test timeout done");
   endtask : t_timo
   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      t_ext();
      t_dir();
      t_edge();
      t_timo();
      // No scenario runs long enough for the timestamp counter to wrap.
      chk("overflow irq", 24'h0, TS_W'(n_ovf));
      print_verdict();
   end
endmodule : thc_hit_select_tb
bind thc_hit_select thc_hit_select_properties #(.TS_W(TS_W)) u_chk (.mclk(mclk),
   .rst_n(rst_n), .analog_enable(analog_enable), .cap_charge_time(cap_charge_time),
   .load_capacitor(load_capacitor), .result(result), .result_valid(result_valid),
   .result_invalid(result_invalid), .irq_hits(irq_hits), .busy(busy));

// [verif/thc_pulse_src.sv]
module thc_pulse_src (
   input wire logic mclk,
   input wire logic ana_sel,
   output logic start_pin,
   output logic stop_a_dig,
   output logic stop_b_dig,
   output logic stop_a_ana,
   output logic stop_b_ana
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lv = 3'h0;
   logic tog = 1'b0;
   // The unused stop path toggles every cycle, so a wrong path choice shows up as extra hits.
   always @(negedge mclk) tog <= ~tog;
   assign start_pin = lv[0];
   assign stop_a_dig = ana_sel ? tog : lv[1];
   assign stop_b_dig = ana_sel ? tog : lv[2];
   assign stop_a_ana = ana_sel ? lv[1] : tog;
   assign stop_b_ana = ana_sel ? lv[2] : tog;
   task automatic pg(input int ch, input int w, input int g);
      lv[ch] = 1'b1;
      repeat (w) @(negedge mclk);
      lv[ch] = 1'b0;
      repeat (g) @(negedge mclk);
   endtask : pg
endmodule : thc_pulse_src
